// *** rtl/cwg_defs.svh ***
/*
  Register offsets, field positions, reset values and widths for the
  complementary waveform unit. Assumes APB byte addresses, one 32-bit word
  per register, and only definitions here.
*/
`ifndef CWG_DEFS_SVH
`define CWG_DEFS_SVH

// register byte offsets
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_STEER 12'h008
`define OFS_DBR 12'h00C
`define OFS_DBF 12'h010
`define OFS_ISEL 12'h014
`define OFS_SHDN 12'h018

// wave_ctrl0 fields
`define C0_EN 7
`define C0_LD 6
`define C0_MODE_HI 2
// wave_ctrl1 fields
`define C1_POL_HI 3
`define C1_RISE_EN 4
`define C1_FALL_EN 5
`define C1_IN_LVL 6
// shutdown register fields
`define SD_SW 7
`define SD_RESTART 6
`define SD_ACTIVE 5
`define SD_OVR_HI 3

`define DB_W 6
`define ISEL_W 4
`define SRC_N 16
`define RST_BYTE 8'h00
`define RST_DB 6'h00

`endif

// *** rtl/cwg_pkg.sv ***
/*
  Types shared by the complementary waveform unit.
  Assumes the constants header is included alongside.
*/
package cwg_pkg;
  // operating mode codes
  typedef enum logic [2:0] {
    MODE_STEER_NOW = 3'h0,
    MODE_STEER_SYNC = 3'h1,
    MODE_FULL_FWD = 3'h2,
    MODE_FULL_REV = 3'h3,
    MODE_HALF = 3'h4,
    MODE_PUSH_PULL = 3'h5
  } mode_e;

  // full-bridge direction state
  typedef enum logic [1:0] {
    DIR_FWD = 2'b01,
    DIR_REV = 2'b10
  } dir_e;

  // one bit per output pin
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } quad_s;
endpackage : cwg_pkg

// *** rtl/deadband_delay.sv ***
/*
  One dead-band timer: delays the rising edge of a level by a count of
  clock periods, falling edge passes after one cycle.
  Assumes level is synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "cwg_defs.svh"
module deadband_delay (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic [`DB_W-1:0] delay,
  // data
  input wire logic level,
  output logic delayed
);
  logic [`DB_W-1:0] cnt; // elapsed periods while level high
  logic [`DB_W-1:0] next_cnt;
  logic next_delayed;

  // count from zero up to the delay value, then pass the level
  always_comb begin
    next_cnt = cnt;
    next_delayed = 1'b0;
    if (clear || !level) begin
      next_cnt = `RST_DB;
    end else if (cnt == delay) begin
      next_delayed = 1'b1;
    end else begin
      next_cnt = cnt + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= `RST_DB;
      delayed <= 1'b0;
    end else begin
      cnt <= next_cnt;
      delayed <= next_delayed;
    end
  end
endmodule : deadband_delay

// *** rtl/cwg_core.sv ***
/*
  Complementary waveform unit top: APB register file, input select,
  half-bridge, push-pull, full-bridge and steering modes, dead-band,
  polarity and auto-shutdown. Assumes all inputs synchronous to ref_clk.
*/
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "cwg_defs.svh"
module cwg_core
  import cwg_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // waveform sources and fault input
  input wire logic [`SRC_N-1:0] src_in,
  input wire logic shutdown_n,
  // gate driver outputs
  output logic out_a,
  output logic out_b,
  output logic out_c,
  output logic out_d
);
  // software registers
  logic [7:0] wave_ctrl0, next_wave_ctrl0;
  logic [7:0] wave_ctrl1, next_wave_ctrl1;
  logic [7:0] steer_reg, next_steer_reg; // low nibble enables, high levels
  logic [`DB_W-1:0] rise_deadband_count, next_rise_deadband_count;
  logic [`DB_W-1:0] fall_deadband_count, next_fall_deadband_count;
  logic [`ISEL_W-1:0] waveform_input_select, next_waveform_input_select;
  logic [7:0] shdn_reg, next_shdn_reg;
  // working copies
  logic [`DB_W-1:0] rise_act, next_rise_act; // double-buffered delays
  logic [`DB_W-1:0] fall_act, next_fall_act;
  logic [3:0] steer_act, next_steer_act; // steering in force
  // waveform state
  logic data_q, next_data_q; // selected input, previous cycle
  logic pp_seq, next_pp_seq; // push-pull: next pulse goes to b
  logic pp_route, next_pp_route; // push-pull: current pulse on b
  dir_e fb_dir, next_fb_dir;
  logic fb_hold, next_fb_hold; // modulated output held for dead-band
  logic [`DB_W-1:0] fb_cnt, next_fb_cnt;
  quad_s outs, next_outs;
  // apb answer
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  // decoded controls
  logic en, data, rise_edge, fall_edge, sd_active, wr, rd_cycle, mapped;
  logic [8:0] rd_word; // read mux output, bit 8 marks a mapped offset
  mode_e mode;
  quad_s pol, steer_en, steer_lvl, ovr, raw;
  logic db_a, db_b;

  // polarity set means active-high; applied to a true (active) level
  function automatic logic pol_apply(input logic act, input logic p);
    pol_apply = p ? act : ~act;
  endfunction : pol_apply

  // register read mux, also used for the mapped check
  function automatic logic [8:0] reg_read(input logic [11:0] a);
    case (a)
      `OFS_CTRL0: reg_read = {1'b1, wave_ctrl0};
      `OFS_CTRL1: reg_read = {1'b1, wave_ctrl1[7] , data_q, wave_ctrl1[5:0]};
      `OFS_STEER: reg_read = {1'b1, steer_reg};
      `OFS_DBR: reg_read = {3'h4, rise_deadband_count};
      `OFS_DBF: reg_read = {3'h4, fall_deadband_count};
      `OFS_ISEL: reg_read = {5'h10, waveform_input_select};
      `OFS_SHDN: reg_read = {1'b1, shdn_reg[7:6], sd_active, shdn_reg[4:0]};
      default: reg_read = 9'h000;
    endcase
  endfunction : reg_read

  assign en = wave_ctrl0[`C0_EN];
  assign mode = mode_e'(wave_ctrl0[`C0_MODE_HI:0]);
  assign data = src_in[waveform_input_select];
  assign rise_edge = data & ~data_q;
  assign fall_edge = ~data & data_q;
  assign pol = quad_s'(wave_ctrl1[`C1_POL_HI:0]);
  // selection about to take hold, so a pin steered off at a rising input never shows a sliver
  assign steer_en = quad_s'(next_steer_act);
  assign steer_lvl = quad_s'(steer_reg[7:4]);
  assign ovr = quad_s'(shdn_reg[`SD_OVR_HI:0]);
  // software request or active-low fault pin
  assign sd_active = shdn_reg[`SD_SW] | ~shutdown_n;
  assign rd_cycle = psel & penable & ~pready;
  assign wr = psel & penable & pready & pwrite;

  // half-bridge dead-band: a waits on rising, b on falling input edge
  deadband_delay u_rise (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(~en),
    .delay(wave_ctrl1[`C1_RISE_EN] ? rise_act : `RST_DB),
    .level(data),
    .delayed(db_a)
  );
  deadband_delay u_fall (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(~en),
    .delay(wave_ctrl1[`C1_FALL_EN] ? fall_act : `RST_DB),
    .level(~data),
    .delayed(db_b)
  );

  // apb answer: one wait state, then data and pready together
  always_comb begin
    // mux evaluated here so it follows register contents, not just the address
    rd_word = reg_read(paddr);
    mapped = rd_word[8];
    next_pready = rd_cycle;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (rd_cycle) begin
      next_prdata = {24'h00_0000, rd_word[7:0]};
      next_pslverr = ~mapped; // unmapped answers with an error
    end
  end

  // software registers, with hardware clears where the block owns them
  always_comb begin
    next_wave_ctrl0 = wave_ctrl0;
    next_wave_ctrl1 = wave_ctrl1;
    next_steer_reg = steer_reg;
    next_rise_deadband_count = rise_deadband_count;
    next_fall_deadband_count = fall_deadband_count;
    next_waveform_input_select = waveform_input_select;
    next_shdn_reg = shdn_reg;
    // hardware clears first, so a software write in the same cycle wins
    if (en && fall_edge) begin
      next_wave_ctrl0[`C0_LD] = 1'b0;
    end
    if (shdn_reg[`SD_RESTART] && rise_edge && shutdown_n) begin
      next_shdn_reg[`SD_SW] = 1'b0; // auto-restart on next rising input
    end
    if (wr) begin
      unique case (paddr)
        `OFS_CTRL0: next_wave_ctrl0 = {pwdata[7:6], 3'h0, pwdata[2:0]};
        `OFS_CTRL1: next_wave_ctrl1 = {2'h0, pwdata[5:0]};
        `OFS_STEER: next_steer_reg = pwdata[7:0];
        `OFS_DBR: next_rise_deadband_count = pwdata[`DB_W-1:0];
        `OFS_DBF: next_fall_deadband_count = pwdata[`DB_W-1:0];
        `OFS_ISEL: next_waveform_input_select = pwdata[`ISEL_W-1:0];
        `OFS_SHDN: next_shdn_reg = {pwdata[7:6], 2'h0, pwdata[3:0]};
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // double buffers and steering copy
  always_comb begin
    next_rise_act = rise_act;
    next_fall_act = fall_act;
    next_steer_act = steer_act;
    // delays load freely while disabled, else on load request at fall
    if (!en || (wave_ctrl0[`C0_LD] && fall_edge)) begin
      next_rise_act = rise_deadband_count;
      next_fall_act = fall_deadband_count;
    end
    if (mode == MODE_STEER_SYNC) begin
      if (rise_edge || !en) begin
        next_steer_act = steer_reg[3:0];
      end
    end else begin
      next_steer_act = steer_reg[3:0];
    end
  end

  // push-pull sequencer and full-bridge direction tracking
  always_comb begin
    next_data_q = data;
    next_pp_seq = pp_seq;
    next_pp_route = pp_route;
    next_fb_dir = fb_dir;
    next_fb_hold = fb_hold;
    next_fb_cnt = fb_cnt;
    if (!en || sd_active) begin
      next_pp_seq = 1'b0;
      next_pp_route = 1'b0;
    end else if (rise_edge) begin
      next_pp_route = pp_seq;
      next_pp_seq = ~pp_seq;
    end
    if (!en) begin
      // no dead-band on start-up, direction taken as written
      next_fb_dir = wave_ctrl0[0] ? DIR_REV : DIR_FWD;
      next_fb_hold = 1'b0;
      next_fb_cnt = `RST_DB;
    end else if (rise_edge && ((fb_dir == DIR_REV) != wave_ctrl0[0])) begin
      next_fb_dir = wave_ctrl0[0] ? DIR_REV : DIR_FWD;
      next_fb_hold = 1'b1;
      next_fb_cnt = `RST_DB;
    end else if (fb_hold && data) begin
      // reverse uses the rising timer, forward the falling one
      if (fb_cnt == (fb_dir == DIR_REV ? rise_act : fall_act)) begin
        next_fb_hold = 1'b0;
      end else begin
        next_fb_cnt = fb_cnt + 6'h01;
      end
    end
  end

  // raw active levels for the current mode, before polarity
  always_comb begin
    raw = '0;
    unique case (mode)
      MODE_HALF: begin
        raw = '{a: db_a, b: db_b, c: db_a, d: db_b};
      end
      MODE_PUSH_PULL: begin
        // route chosen at the rising input itself, so the other leg never blips
        raw.a = data & ~(rise_edge ? pp_seq : pp_route);
        raw.b = data & (rise_edge ? pp_seq : pp_route);
        raw.c = raw.a;
        raw.d = raw.b;
      end
      MODE_FULL_FWD, MODE_FULL_REV: begin
        // next direction, not the mode bit: a and c move at the rising edge and
        // the old modulated leg cannot fire once more while the bridge turns
        if (next_fb_dir == DIR_FWD) begin
          raw.a = 1'b1;
          raw.d = data & ~next_fb_hold;
        end else begin
          raw.c = 1'b1;
          raw.b = data & ~next_fb_hold;
        end
      end
      default: begin
        raw = '{a: data, b: data, c: data, d: data};
      end
    endcase
  end

  // final pin levels
  always_comb begin
    next_outs = '0;
    if (!en) begin
      next_outs = quad_s'(~pol);
    end else if (mode == MODE_STEER_NOW || mode == MODE_STEER_SYNC) begin
      for (int i = 0; i < 4; i++) begin
        if (!steer_en[i]) begin
          next_outs[i] = steer_lvl[i];
        end else if (sd_active) begin
          next_outs[i] = ovr[i]; // shutdown touches steered pins only
        end else begin
          next_outs[i] = pol_apply(raw[i], pol[i]);
        end
      end
    end else if (sd_active) begin
      next_outs = ovr;
    end else begin
      for (int i = 0; i < 4; i++) begin
        next_outs[i] = pol_apply(raw[i], pol[i]);
      end
    end
  end

  // all state registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wave_ctrl0 <= `RST_BYTE;
      wave_ctrl1 <= `RST_BYTE;
      steer_reg <= `RST_BYTE;
      rise_deadband_count <= `RST_DB;
      fall_deadband_count <= `RST_DB;
      waveform_input_select <= 4'h0;
      shdn_reg <= `RST_BYTE;
      rise_act <= `RST_DB;
      fall_act <= `RST_DB;
      steer_act <= 4'h0;
      data_q <= 1'b0;
      pp_seq <= 1'b0;
      pp_route <= 1'b0;
      fb_dir <= DIR_FWD;
      fb_hold <= 1'b0;
      fb_cnt <= `RST_DB;
      outs <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      wave_ctrl0 <= next_wave_ctrl0;
      wave_ctrl1 <= next_wave_ctrl1;
      steer_reg <= next_steer_reg;
      rise_deadband_count <= next_rise_deadband_count;
      fall_deadband_count <= next_fall_deadband_count;
      waveform_input_select <= next_waveform_input_select;
      shdn_reg <= next_shdn_reg;
      rise_act <= next_rise_act;
      fall_act <= next_fall_act;
      steer_act <= next_steer_act;
      data_q <= next_data_q;
      pp_seq <= next_pp_seq;
      pp_route <= next_pp_route;
      fb_dir <= next_fb_dir;
      fb_hold <= next_fb_hold;
      fb_cnt <= next_fb_cnt;
      outs <= next_outs;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  assign out_a = outs.a;
  assign out_b = outs.b;
  assign out_c = outs.c;
  assign out_d = outs.d;
endmodule : cwg_core

// *** tb/cwg_core_props.sv ***
/*
  port checker for cwg_core: apb timing, reset levels, idle and push-pull pins.
  assumes aligned apb addresses and a bind to every cwg_core instance.
*/
`timescale 1ns/1ps
module cwg_core_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // fault and pins
  input wire logic shutdown_n,
  input wire logic out_a,
  input wire logic out_b,
  input wire logic out_c,
  input wire logic out_d
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic en_m; // mirrored enable
  logic [2:0] mode_m; // mirrored mode
  logic [3:0] pol_m; // mirrored polarity
  logic [1:0] quiet; // cycles since the last write, saturating
  logic next_en_m;
  logic [2:0] next_mode_m;
  logic [3:0] next_pol_m;
  logic [1:0] next_quiet;
  wire wr_done = psel && penable && pready && pwrite;
  wire [3:0] pins = {out_a, out_b, out_c, out_d};
  // mirror of control fields; quiet hides the one-cycle pin latency
  always_comb begin
    next_en_m = en_m;
    next_mode_m = mode_m;
    next_pol_m = pol_m;
    next_quiet = (quiet == 2'h3) ? quiet : quiet + 2'h1;
    if (wr_done) begin
      next_quiet = 2'h0;
      if (paddr == 12'h000) begin
        next_en_m = pwdata[7];
        next_mode_m = pwdata[2:0];
      end
      if (paddr == 12'h004) begin
        next_pol_m = pwdata[3:0];
      end
    end
  end
  // registers only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      {en_m, mode_m, pol_m, quiet} <= 10'h000;
    end else begin
      {en_m, mode_m, pol_m, quiet} <= {next_en_m, next_mode_m, next_pol_m, next_quiet};
    end
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wait_s;
    psel && penable && !pready ##1 pready;
  endsequence
  apb_wait_a: assert property (setup_s |=> wait_s) else $error("apb wait state wrong");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  err_map_a: assert property (pslverr == (pready && paddr > 12'h018)) else $error("pslverr mismatch");
  rdata_idle_a: assert property (prdata[31:8] == 24'h0 && (pready || prdata == 32'h0)) else $error("prdata not idle");
  reset_low_a: assert property (disable iff (1'b0) rst |-> pins == 4'h0) else $error("pins not low in reset");
  release_idle_a: assert property ($fell(rst) |=> pins == 4'hF) else $error("pins not idle after reset");
  disabled_idle_a: assert property (!en_m && quiet == 2'h3 && shutdown_n |-> pins == ~pol_m)
    else $error("disabled pins not inactive");
  overlap_a: assert property (en_m && mode_m[2:1] == 2'b10 && quiet == 2'h3 && shutdown_n
    |-> !(out_a == pol_m[3] && out_b == pol_m[2])) else $error("a and b active together");
  pp_copy_a: assert property (en_m && mode_m == 3'h5 && shutdown_n && $past(shutdown_n)
    |-> (out_c ^ pol_m[1]) == (out_a ^ pol_m[3]) && (out_d ^ pol_m[0]) == (out_b ^ pol_m[2]))
    else $error("c or d not copying");
endmodule : cwg_core_props

bind cwg_core cwg_core_props u_props (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shutdown_n(shutdown_n), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));

// *** tb/gate_driver_model.sv ***
/*
  gate driver stand-in: counts switch-on edges of the a and b legs.
  assumes registered pins on ref_clk, active high on those legs.
*/
`timescale 1ns/1ps
module gate_driver_model (
  // clock
  input wire logic ref_clk,
  // driven legs
  input wire logic out_a,
  input wire logic out_b,
  // switch-on counts, only deltas matter
  output logic [7:0] cnt_a,
  output logic [7:0] cnt_b
);
  logic last_a = 1'b0; // previous leg levels
  logic last_b = 1'b0;
  initial begin
    cnt_a = 8'h00;
    cnt_b = 8'h00;
  end
  // one switch-on per leg per routed pulse
  always @(posedge ref_clk) begin
    last_a <= out_a;
    last_b <= out_b;
    if (out_a && !last_a) begin
      cnt_a <= cnt_a + 8'h01;
    end
    if (out_b && !last_b) begin
      cnt_b <= cnt_b + 8'h01;
    end
  end
endmodule : gate_driver_model

// *** tb/cwg_core_tb_top.sv ***
/*
  bench for cwg_core: registers, steering, dead-band, push-pull, full-bridge, shutdown.
  assumes the checker bind and the gate driver model are compiled first.
*/
`timescale 1ns/1ps
`include "cwg_defs.svh"
module cwg_core_tb_top
  import cwg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, cfg;
  logic pready, pslverr, er, out_a, out_b, out_c, out_d;
  logic [`SRC_N-1:0] src_in = 16'h0000;
  logic shutdown_n = 1'b1;
  logic [7:0] cnt_a, cnt_b, a0, b0;
  logic [3:0] isel; // selected source
  logic [31:0] seed = 32'hD289;
  int n;
  int miscompares = 0;
  int cmp_count = 0;
  wire [3:0] pins = {out_a, out_b, out_c, out_d};
  cwg_core DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
    .shutdown_n(shutdown_n), .out_a(out_a), .out_b(out_b), .out_c(out_c), .out_d(out_d));
  gate_driver_model drv (.ref_clk(ref_clk), .out_a(out_a), .out_b(out_b), .cnt_a(cnt_a), .cnt_b(cnt_b));
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  // steered pins follow data through polarity, others show raw fixed level
  function automatic logic [3:0] steer_exp(input logic [7:0] s, input logic [3:0] p, input logic v);
    return (s[3:0] & ({4{v}} ~^ p)) | (~s[3:0] & s[7:4]);
  endfunction : steer_exp
  task automatic results();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc
  // one apb transfer, entered just after an edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      chk(32'(pready), 32'h1);
      results();
    end
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr
  // selected source carries v, the rest is noise
  task automatic drive(input logic v);
    src_in <= (16'(xorshift()) & ~(16'h1 << isel)) | (16'(v) << isel);
  endtask : drive
  task automatic pulse();
    drive(1'b1);
    cyc(4);
    drive(1'b0);
    cyc(4);
  endtask : pulse
  // edges until pin i shows v; bounded
  task automatic meas(input int i, input logic v);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pins[i] !== v && n < 80);
    if (pins[i] !== v) begin
      chk(32'(pins[i]), 32'(v));
      results();
    end
  endtask : meas
  initial begin
    rst <= 1'b1;
    isel = 4'(xorshift());
    cyc(8);
    rst <= 1'b0;
    cyc(3);
    chk(32'(pins), 32'hF);
    apb(1'b0, `OFS_CTRL0, 32'h0);
    chk(rd, 32'h0);
    wr(`OFS_DBR, 8'hFF);
    apb(1'b0, `OFS_DBR, 32'h0);
    chk(rd, 32'h3F);
    apb(1'b0, 12'h01C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    wr(`OFS_ISEL, {4'h0, isel});
    wr(`OFS_CTRL1, 8'h0A);
    cyc(3);
    chk(32'(pins), 32'h5);
    // immediate steering with random routes, levels and polarity
    for (int k = 0; k < 16; k++) begin
      cfg = xorshift();
      wr(`OFS_CTRL1, {4'h0, cfg[11:8]});
      wr(`OFS_STEER, cfg[7:0]);
      if (k == 0) wr(`OFS_CTRL0, 8'h80 | 8'(MODE_STEER_NOW));
      drive(cfg[12]);
      cyc(4);
      chk(32'(pins), 32'(steer_exp(cfg[7:0], cfg[11:8], cfg[12])));
    end
    // synchronous steering waits for a rising input
    wr(`OFS_CTRL1, 8'h0F);
    wr(`OFS_STEER, 8'h0F);
    drive(1'b0);
    wr(`OFS_CTRL0, 8'h80 | 8'(MODE_STEER_SYNC));
    wr(`OFS_STEER, 8'hF0);
    cyc(4);
    chk(32'(pins), 32'h0);
    drive(1'b1);
    cyc(4);
    chk(32'(pins), 32'hF);
    // half-bridge dead-band, one case with rising delay switched off
    for (int k = 0; k < 3; k++) begin
      cfg = xorshift();
      if (k == 1) cfg[5:0] = 6'h3F;
      wr(`OFS_CTRL0, 8'h00);
      drive(1'b0);
      wr(`OFS_DBR, {2'h0, cfg[5:0]});
      wr(`OFS_DBF, {2'h0, cfg[13:8]});
      wr(`OFS_CTRL1, (k == 2) ? 8'h2F : 8'h3F);
      wr(`OFS_CTRL0, 8'h80 | 8'(MODE_HALF));
      cyc(70);
      drive(1'b1);
      meas(3, 1'b1);
      chk(32'(n), (k == 2) ? 32'd3 : 32'(cfg[5:0]) + 32'd3);
      chk(32'({out_c, out_d}), 32'({out_a, out_b}));
      drive(1'b0);
      meas(2, 1'b1);
      chk(32'(n), 32'(cfg[13:8]) + 32'd3);
    end
    // push-pull alternation and sequencer restart
    wr(`OFS_CTRL0, 8'h00);
    wr(`OFS_CTRL1, 8'h0D);
    wr(`OFS_CTRL0, 8'h80 | 8'(MODE_PUSH_PULL));
    a0 = cnt_a;
    b0 = cnt_b;
    for (int k = 0; k < 5; k++) begin
      pulse();
      chk(32'(8'(cnt_a - a0)), 32'(k / 2 + 1));
      chk(32'(8'(cnt_b - b0)), 32'((k + 1) / 2));
    end
    wr(`OFS_CTRL0, 8'h00);
    wr(`OFS_CTRL0, 8'h80 | 8'(MODE_PUSH_PULL));
    pulse();
    chk(32'(8'(cnt_a - a0)), 32'h4);
    // full bridge forward, then reverse while running
    wr(`OFS_CTRL0, 8'h00);
    wr(`OFS_DBR, 8'h08);
    wr(`OFS_DBF, 8'h08);
    wr(`OFS_CTRL1, 8'h3F);
    wr(`OFS_CTRL0, 8'h80 | 8'(MODE_FULL_FWD));
    pulse();
    pulse();
    drive(1'b1);
    cyc(5);
    chk(32'(pins), 32'h9);
    drive(1'b0);
    cyc(5);
    chk(32'(pins), 32'h8);
    wr(`OFS_CTRL0, 8'h80 | 8'(MODE_FULL_REV));
    cyc(4);
    chk(32'(pins), 32'h8);
    drive(1'b1);
    cyc(5);
    chk(32'(pins), 32'h2);
    meas(2, 1'b1);
    chk(32'(n > 5), 32'h1);
    chk(32'(pins), 32'h6);
    drive(1'b0);
    cyc(5);
    drive(1'b1);
    meas(2, 1'b1);
    chk(32'(n < 6), 32'h1);
    // fault pin in every mode, raw override levels
    for (int m = 0; m < 6; m++) begin
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(3);
      wr(`OFS_SHDN, 8'h0A ^ 8'(m));
      wr(`OFS_STEER, 8'h0F);
      wr(`OFS_CTRL0, 8'h80 | 8'(m));
      pulse();
      shutdown_n <= 1'b0;
      cyc(3);
      chk(32'(pins), 32'(4'hA ^ 4'(m)));
      apb(1'b0, `OFS_SHDN, 32'h0);
      chk(32'(rd[5]), 32'h1);
      shutdown_n <= 1'b1;
    end
    results();
  end
endmodule : cwg_core_tb_top
